// ### verilog/lat_pkg.sv
/*
 * Shared constants for the lane alarm and trim register slice: register
 * indices, field positions, reset values and the trim-load state type.
 * Assumes a word-addressed APB map where byte address = index * 4.
 */
package lat_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indices (byte address is four times the index)
    localparam logic [9:0] IDX_ALARM_STATUS = 10'h2c1;
    localparam logic [9:0] IDX_LANE_FLAGS = 10'h2c4;
    localparam logic [9:0] IDX_DUAL_A = 10'h310;
    localparam logic [9:0] IDX_DUAL_B = 10'h313;
    localparam logic [9:0] IDX_SGL_A_IN1 = 10'h314;
    localparam logic [9:0] IDX_SGL_B_IN1 = 10'h315;
    localparam logic [9:0] IDX_SGL_A_IN2 = 10'h31a;
    localparam logic [9:0] IDX_SGL_B_IN2 = 10'h31b;
    localparam logic [9:0] IDX_OFS_A_DUAL_IN1 = 10'h344;
    localparam logic [9:0] IDX_MODE = 10'h380;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h381;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h382;

    ////////////////////////////////////////////////////////////////////////
    // Field positions and reset values
    localparam int SUMMARY_BIT = 5;
    localparam logic [15:0] LANE_FLAGS_RST = 16'hffff;
    localparam logic SUMMARY_RST = 1'h1;
    localparam logic [7:0] TRIM_RST = 8'h00;
    localparam logic [11:0] OFS_RST = 12'h000;
    localparam int MODE_DUAL_BIT = 0;
    localparam int MODE_FG_BIT = 1;
    localparam int MODE_INSEL_BIT = 2;
    localparam int MODE_W = 3;
    localparam logic [2:0] MODE_RST = 3'h1;
    localparam int IRQ_LANE_BIT = 0;
    localparam int IRQ_LOAD_BIT = 1;
    localparam int IRQ_W = 2;
    localparam logic [1:0] IRQ_STATUS_RST = 2'h0;
    localparam logic [1:0] IRQ_MASK_RST = 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // Factory trim load sequencer
    typedef enum logic [2:0] {
        LAT_LD_WAIT = 3'b001,
        LAT_LD_COPY = 3'b010,
        LAT_LD_DONE = 3'b100
    } lat_load_state_t;

    // Word index match of a byte address
    function automatic logic idx_hit(input logic [11:0] addr, input logic [9:0] idx);
        return addr[11:2] == idx;
    endfunction

endpackage

// ### verilog/lat_lane_alarm.sv
/*
 * Per-lane FIFO alarm vector and its summary flag.
 * Assumes lane error inputs are synchronous to pclk and that clear strobes
 * are one-cycle pulses from the register decoder.
 */
`timescale 1ns/1ns

module lat_lane_alarm #(
    parameter int LANES = 16
) (
    input wire logic pclk,                    // Bus clock
    input wire logic presetn,                 // Async reset, active low
    input wire logic [LANES-1:0] lane_err,    // Overflow/underflow per lane
    input wire logic [LANES-1:0] lane_active, // Lanes in use
    input wire logic [LANES-1:0] lane_clr,    // Write-one-to-clear per lane
    input wire logic sum_clr,                 // Clear summary and all lanes
    output logic [LANES-1:0] flags_q,         // Per-lane alarm vector
    output logic summary_q                    // Summary alarm flag
);

    ////////////////////////////////////////////////////////////////////////
    // Next values: a new error wins over a clear in the same cycle
    logic [LANES-1:0] flags_d;
    logic summary_d;
    logic any_active_err;

    assign any_active_err = |(lane_err & lane_active);
    assign flags_d = (flags_q & ~(lane_clr | {LANES{sum_clr}})) | lane_err;
    assign summary_d = (summary_q & ~sum_clr) | any_active_err;

    // Alarm state; everything reads as tripped after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= LANES'(lat_pkg::LANE_FLAGS_RST);
            summary_q <= lat_pkg::SUMMARY_RST;
        end else begin
            flags_q <= flags_d;
            summary_q <= summary_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_lane_err_sets: assert property (
        (|lane_err) |=> ((flags_q & $past(lane_err)) == $past(lane_err)))
        else $error("lane error did not set its flag");

    a_lane_w1c: assert property (
        (|lane_clr && lane_err == '0) |=> ((flags_q & $past(lane_clr)) == '0))
        else $error("lane flag not cleared by write of one");

    a_summary_clears_all: assert property (
        (sum_clr && lane_err == '0) |=> (flags_q == '0 && !summary_q))
        else $error("summary clear left lane flags set");

    a_summary_sets: assert property (
        (|(lane_err & lane_active)) |=> summary_q [*1] ##0 (flags_q != '0))
        else $error("summary flag missed an active lane error");

endmodule

// ### verilog/lat_trim_select.sv
/*
 * Selects the timing and offset trims that reach each converter core
 * from the channel mode, calibration mode and sampled input.
 * Assumes all register inputs are stable flops from the register file.
 */
`timescale 1ns/1ns

module lat_trim_select #(
    parameter int TRIM_W = 8,
    parameter int OFS_W = 12
) (
    input wire logic pclk,                      // Bus clock
    input wire logic presetn,                   // Async reset, active low
    input wire logic dual_mode,                 // 1: dual channel, 0: single
    input wire logic fg_cal_en,                 // Foreground calibration on
    input wire logic in_sel,                    // 0: first_analog_input
    input wire logic [TRIM_W-1:0] dual_a,       // Core A dual trim
    input wire logic [TRIM_W-1:0] dual_b,       // Core B dual trim
    input wire logic [TRIM_W-1:0] sgl_a_in1,    // Core A single, input 1
    input wire logic [TRIM_W-1:0] sgl_b_in1,    // Core B single, input 1
    input wire logic [TRIM_W-1:0] sgl_a_in2,    // Core A single, input 2
    input wire logic [TRIM_W-1:0] sgl_b_in2,    // Core B single, input 2
    input wire logic [OFS_W-1:0] ofs_a,         // Core A dual input-1 offset
    output logic [TRIM_W-1:0] core_a_timing_q,  // Applied core A timing
    output logic [TRIM_W-1:0] core_b_timing_q,  // Applied core B timing
    output logic [OFS_W-1:0] core_a_offset_q,   // Applied core A offset
    output logic core_a_offset_valid_q          // Offset trim in force
);

    ////////////////////////////////////////////////////////////////////////
    // Selection; single channel without calibration keeps the dual trims
    logic sgl_fg;
    logic ofs_use;
    logic [TRIM_W-1:0] a_d;
    logic [TRIM_W-1:0] b_d;

    assign sgl_fg = !dual_mode && fg_cal_en;
    assign a_d = sgl_fg ? (in_sel ? sgl_a_in2 : sgl_a_in1) : dual_a;
    assign b_d = sgl_fg ? (in_sel ? sgl_b_in2 : sgl_b_in1) : dual_b;
    // offset for dual, calibrated, first input
    assign ofs_use = dual_mode && fg_cal_en && !in_sel;

    // Registered so the analog side never sees a decode glitch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_a_timing_q <= TRIM_W'(lat_pkg::TRIM_RST);
            core_b_timing_q <= TRIM_W'(lat_pkg::TRIM_RST);
            core_a_offset_q <= OFS_W'(lat_pkg::OFS_RST);
            core_a_offset_valid_q <= 1'b0;
        end else begin
            core_a_timing_q <= a_d;
            core_b_timing_q <= b_d;
            core_a_offset_q <= ofs_use ? ofs_a : OFS_W'(lat_pkg::OFS_RST);
            core_a_offset_valid_q <= ofs_use;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_dual_core_map: assert property (
        dual_mode |=> (core_a_timing_q == $past(dual_a)
                       && core_b_timing_q == $past(dual_b)))
        else $error("dual mode trims not applied to cores");

    a_single_fg_map: assert property (
        (sgl_fg && in_sel) |=> (core_a_timing_q == $past(sgl_a_in2)
                                && core_b_timing_q == $past(sgl_b_in2)))
        else $error("single mode second input trims not applied");

    a_offset_apply: assert property (
        (dual_mode && fg_cal_en && !in_sel) |=>
            (core_a_offset_valid_q && core_a_offset_q == $past(ofs_a)))
        else $error("offset trim not applied in dual calibrated mode");

endmodule

// ### verilog/lat_regs_top.sv
/*
 * APB register slice holding the lane FIFO alarms, the timing trims and
 * the core A offset trim, with a sticky interrupt and a factory trim load.
 * Assumes a zero-wait APB master, fuse values valid from reset release,
 * and lane error inputs synchronous to pclk.
 */
// Added by the designer: the APB interface to the registers.
// Contract
// - Lane i overflow or underflow sets alarm bit i; all bits reset to one.
// - Writing one to an alarm bit clears it; a persisting error re-sets it.
// - Writing one to the summary bit clears the whole lane alarm vector.
// - Summary bit 5 of alarm status sets on any active lane error.
// - Each 8-bit timing trim register holds a core sampling instant value.
// - Timing trims load factory values at power-up; software reads and overwrites.
// - Dual channel mode applies first trim to core A, second to core B.
// - Single mode with calibration picks trim by core and sampled input.
// - 12-bit offset trim applies to core A, dual, calibrated, first input.
`timescale 1ns/1ns

module lat_regs_top #(
    parameter int LANES = 16,
    parameter int TRIM_W = 8,
    parameter int OFS_W = 12
) (
    input wire logic pclk,                      // Bus clock, 25 MHz
    input wire logic presetn,                   // Async reset, active low
    input wire logic psel,                      // APB select
    input wire logic penable,                   // APB access phase
    input wire logic pwrite,                    // APB write
    input wire logic [11:0] paddr,              // APB byte address
    input wire logic [31:0] pwdata,             // APB write data
    output logic [31:0] prdata,                 // APB read data
    output logic pready,                        // APB ready
    output logic pslverr,                       // APB error, unmapped
    input wire logic [LANES-1:0] lane_fifo_err, // Lane FIFO over/underflow
    input wire logic [LANES-1:0] lane_active,   // Lanes in use
    input wire logic [TRIM_W-1:0] fuse_dual_a,  // Factory trim values
    input wire logic [TRIM_W-1:0] fuse_dual_b,  // Factory trim
    input wire logic [TRIM_W-1:0] fuse_sgl_a_in1, // Factory trim
    input wire logic [TRIM_W-1:0] fuse_sgl_b_in1, // Factory trim
    input wire logic [TRIM_W-1:0] fuse_sgl_a_in2, // Factory trim
    input wire logic [TRIM_W-1:0] fuse_sgl_b_in2, // Factory trim
    input wire logic [OFS_W-1:0] fuse_ofs_a,    // Factory offset trim
    output logic [TRIM_W-1:0] core_a_timing,    // Applied core A timing
    output logic [TRIM_W-1:0] core_b_timing,    // Applied core B timing
    output logic [OFS_W-1:0] core_a_offset,     // Applied core A offset
    output logic core_a_offset_valid,           // Offset trim in force
    output logic irq                            // Interrupt, level
);

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [TRIM_W-1:0] dual_a_q;
    logic [TRIM_W-1:0] dual_b_q;
    logic [TRIM_W-1:0] sgl_a_in1_q;
    logic [TRIM_W-1:0] sgl_b_in1_q;
    logic [TRIM_W-1:0] sgl_a_in2_q;
    logic [TRIM_W-1:0] sgl_b_in2_q;
    logic [OFS_W-1:0] ofs_a_q;
    logic [lat_pkg::MODE_W-1:0] mode_q;
    logic [lat_pkg::IRQ_W-1:0] irq_stat_q;
    logic [lat_pkg::IRQ_W-1:0] irq_stat_d;
    logic [lat_pkg::IRQ_W-1:0] irq_mask_q;
    logic [lat_pkg::IRQ_W-1:0] irq_set;
    logic [lat_pkg::IRQ_W-1:0] irq_clr;
    logic [31:0] prdata_q;
    logic [LANES-1:0] lane_flags;
    logic summary_flag;
    lat_pkg::lat_load_state_t ld_state_q;
    lat_pkg::lat_load_state_t ld_state_d;

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    logic access;
    logic wr_acc;
    logic rd_acc;
    logic hit_alarm;
    logic hit_flags;
    logic hit_dual_a;
    logic hit_dual_b;
    logic hit_a_in1;
    logic hit_b_in1;
    logic hit_a_in2;
    logic hit_b_in2;
    logic hit_ofs;
    logic hit_mode;
    logic hit_istat;
    logic hit_imask;
    logic mapped;
    logic ld_done;
    logic ld_copy;

    assign ld_done = ld_state_q == lat_pkg::LAT_LD_DONE;
    assign ld_copy = ld_state_q == lat_pkg::LAT_LD_COPY;
    // Bus stalls until the factory load is over, then answers at once
    assign pready = ld_done;
    assign access = psel && penable && pready;
    assign wr_acc = access && pwrite;
    assign rd_acc = access && !pwrite;
    assign hit_alarm = lat_pkg::idx_hit(paddr, lat_pkg::IDX_ALARM_STATUS);
    assign hit_flags = lat_pkg::idx_hit(paddr, lat_pkg::IDX_LANE_FLAGS);
    assign hit_dual_a = lat_pkg::idx_hit(paddr, lat_pkg::IDX_DUAL_A);
    assign hit_dual_b = lat_pkg::idx_hit(paddr, lat_pkg::IDX_DUAL_B);
    assign hit_a_in1 = lat_pkg::idx_hit(paddr, lat_pkg::IDX_SGL_A_IN1);
    assign hit_b_in1 = lat_pkg::idx_hit(paddr, lat_pkg::IDX_SGL_B_IN1);
    assign hit_a_in2 = lat_pkg::idx_hit(paddr, lat_pkg::IDX_SGL_A_IN2);
    assign hit_b_in2 = lat_pkg::idx_hit(paddr, lat_pkg::IDX_SGL_B_IN2);
    assign hit_ofs = lat_pkg::idx_hit(paddr, lat_pkg::IDX_OFS_A_DUAL_IN1);
    assign hit_mode = lat_pkg::idx_hit(paddr, lat_pkg::IDX_MODE);
    assign hit_istat = lat_pkg::idx_hit(paddr, lat_pkg::IDX_IRQ_STATUS);
    assign hit_imask = lat_pkg::idx_hit(paddr, lat_pkg::IDX_IRQ_MASK);
    assign mapped = hit_alarm | hit_flags | hit_dual_a | hit_dual_b | hit_a_in1
                  | hit_b_in1 | hit_a_in2 | hit_b_in2 | hit_ofs | hit_mode
                  | hit_istat | hit_imask;
    assign pslverr = access && !mapped;

    ////////////////////////////////////////////////////////////////////////
    // Read multiplexer; unmapped and reserved bits read zero
    logic [31:0] rd_mux;

    assign rd_mux =
        hit_alarm ? 32'(summary_flag) << lat_pkg::SUMMARY_BIT :
        hit_flags ? 32'(lane_flags) :
        hit_dual_a ? 32'(dual_a_q) :
        hit_dual_b ? 32'(dual_b_q) :
        hit_a_in1 ? 32'(sgl_a_in1_q) :
        hit_b_in1 ? 32'(sgl_b_in1_q) :
        hit_a_in2 ? 32'(sgl_a_in2_q) :
        hit_b_in2 ? 32'(sgl_b_in2_q) :
        hit_ofs ? 32'(ofs_a_q) :
        hit_mode ? 32'(mode_q) :
        hit_istat ? 32'(irq_stat_q) :
        hit_imask ? 32'(irq_mask_q) : 32'h0000_0000;

    // Read data captured while the request waits, held through the answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !access) begin
            prdata_q <= rd_mux;
        end
    end
    assign prdata = prdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Factory trim load after reset release
    always_comb begin
        case (ld_state_q)
            lat_pkg::LAT_LD_WAIT: ld_state_d = lat_pkg::LAT_LD_COPY;
            lat_pkg::LAT_LD_COPY: ld_state_d = lat_pkg::LAT_LD_DONE;
            lat_pkg::LAT_LD_DONE: ld_state_d = lat_pkg::LAT_LD_DONE;
            default: ld_state_d = lat_pkg::LAT_LD_WAIT;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ld_state_q <= lat_pkg::LAT_LD_WAIT;
        end else begin
            ld_state_q <= ld_state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trim registers: fuse copy first, software writes after
    // load then read/write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dual_a_q <= TRIM_W'(lat_pkg::TRIM_RST);
            dual_b_q <= TRIM_W'(lat_pkg::TRIM_RST);
            sgl_a_in1_q <= TRIM_W'(lat_pkg::TRIM_RST);
            sgl_b_in1_q <= TRIM_W'(lat_pkg::TRIM_RST);
            sgl_a_in2_q <= TRIM_W'(lat_pkg::TRIM_RST);
            sgl_b_in2_q <= TRIM_W'(lat_pkg::TRIM_RST);
        end else if (ld_copy) begin
            dual_a_q <= fuse_dual_a;
            dual_b_q <= fuse_dual_b;
            sgl_a_in1_q <= fuse_sgl_a_in1;
            sgl_b_in1_q <= fuse_sgl_b_in1;
            sgl_a_in2_q <= fuse_sgl_a_in2;
            sgl_b_in2_q <= fuse_sgl_b_in2;
        end else if (wr_acc) begin
            if (hit_dual_a) dual_a_q <= pwdata[TRIM_W-1:0];
            if (hit_dual_b) dual_b_q <= pwdata[TRIM_W-1:0];
            if (hit_a_in1) sgl_a_in1_q <= pwdata[TRIM_W-1:0];
            if (hit_b_in1) sgl_b_in1_q <= pwdata[TRIM_W-1:0];
            if (hit_a_in2) sgl_a_in2_q <= pwdata[TRIM_W-1:0];
            if (hit_b_in2) sgl_b_in2_q <= pwdata[TRIM_W-1:0];
        end
    end

    // Offset trim keeps only its low field; upper bits read zero
    // offset register storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ofs_a_q <= OFS_W'(lat_pkg::OFS_RST);
        end else if (ld_copy) begin
            ofs_a_q <= fuse_ofs_a;
        end else if (wr_acc && hit_ofs) begin
            ofs_a_q <= pwdata[OFS_W-1:0];
        end
    end

    // Mode and interrupt mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= lat_pkg::MODE_RST;
            irq_mask_q <= lat_pkg::IRQ_MASK_RST;
        end else if (wr_acc) begin
            if (hit_mode) mode_q <= pwdata[lat_pkg::MODE_W-1:0];
            if (hit_imask) irq_mask_q <= pwdata[lat_pkg::IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status: clear only the bits the read returned, so an event
    // landing between capture and completion is never lost
    assign irq_set[lat_pkg::IRQ_LANE_BIT] = |lane_fifo_err;
    assign irq_set[lat_pkg::IRQ_LOAD_BIT] = ld_copy;
    assign irq_clr = (rd_acc && hit_istat) ? prdata_q[lat_pkg::IRQ_W-1:0] : '0;
    assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= lat_pkg::IRQ_STATUS_RST;
        end else begin
            irq_stat_q <= irq_stat_d;
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    ////////////////////////////////////////////////////////////////////////
    // Lane alarms
    logic [LANES-1:0] lane_clr;
    logic sum_clr;

    assign lane_clr = (wr_acc && hit_flags) ? pwdata[LANES-1:0] : '0;
    assign sum_clr = wr_acc && hit_alarm && pwdata[lat_pkg::SUMMARY_BIT];

    lat_lane_alarm #(
        .LANES(LANES)
    ) u_alarm (
        .pclk(pclk),
        .presetn(presetn),
        .lane_err(lane_fifo_err),
        .lane_active(lane_active),
        .lane_clr(lane_clr),
        .sum_clr(sum_clr),
        .flags_q(lane_flags),
        .summary_q(summary_flag)
    );

    ////////////////////////////////////////////////////////////////////////
    // Trim application to the cores
    lat_trim_select #(
        .TRIM_W(TRIM_W),
        .OFS_W(OFS_W)
    ) u_select (
        .pclk(pclk),
        .presetn(presetn),
        .dual_mode(mode_q[lat_pkg::MODE_DUAL_BIT]),
        .fg_cal_en(mode_q[lat_pkg::MODE_FG_BIT]),
        .in_sel(mode_q[lat_pkg::MODE_INSEL_BIT]),
        .dual_a(dual_a_q),
        .dual_b(dual_b_q),
        .sgl_a_in1(sgl_a_in1_q),
        .sgl_b_in1(sgl_b_in1_q),
        .sgl_a_in2(sgl_a_in2_q),
        .sgl_b_in2(sgl_b_in2_q),
        .ofs_a(ofs_a_q),
        .core_a_timing_q(core_a_timing),
        .core_b_timing_q(core_b_timing),
        .core_a_offset_q(core_a_offset),
        .core_a_offset_valid_q(core_a_offset_valid)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_load_copy;
        ld_state_q == lat_pkg::LAT_LD_WAIT ##1 ld_state_q == lat_pkg::LAT_LD_COPY;
    endsequence

    a_fuse_load_copy: assert property (
        s_load_copy |=> (dual_a_q == $past(fuse_dual_a)
                         && sgl_b_in2_q == $past(fuse_sgl_b_in2)
                         && ofs_a_q == $past(fuse_ofs_a) && pready))
        else $error("factory trims not loaded after reset");

    a_trim_write_store: assert property (
        (wr_acc && hit_a_in2) |=> (sgl_a_in2_q == $past(pwdata[TRIM_W-1:0]))
                                  ##1 (sgl_a_in2_q == $past(sgl_a_in2_q) || $past(wr_acc)))
        else $error("timing trim write not stored");

    a_summary_read_back: assert property (
        (|(lane_fifo_err & lane_active)) |=> ##1 (summary_flag || $past(sum_clr)))
        else $error("summary alarm not visible after active lane error");

endmodule

// ### test/lat_lane_model.sv
/*
 * Lane FIFO and fuse bank model facing the register slice.
 * Assumes the bench drives req on rising pclk edges.
 */
`timescale 1ns/1ns

module lat_lane_model #(
    parameter logic [7:0] FUSE = 8'h5a
) (
    input wire logic pclk,        // Bus clock
    input wire logic [15:0] req,  // Lanes to fault
    output logic [15:0] err,      // Over/underflow per lane
    output logic [7:0] fuse       // Trim base value
);
    // Fuse bank base; the bench offsets it per trim
    assign fuse = FUSE;

    ////////////////////////////////////////////////////////////////////////
    // Faults show one edge late, as a FIFO status flop would
    always_ff @(posedge pclk) begin
        err <= req;
    end
endmodule

// ### test/tb_top.sv
/*
 * Self-checking bench for the lane alarm and trim register slice.
 * Assumes an APB slave that stalls only during the trim load.
 */
`timescale 1ns/1ns

module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, ov, perr;
    logic [11:0] paddr, ofs;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] req, err, act;
    logic [7:0] fz, ca, cb;
    logic [2:0] m;
    logic [9:0] tidx [6] = '{lat_pkg::IDX_DUAL_A, lat_pkg::IDX_DUAL_B,
        lat_pkg::IDX_SGL_A_IN1, lat_pkg::IDX_SGL_B_IN1,
        lat_pkg::IDX_SGL_A_IN2, lat_pkg::IDX_SGL_B_IN2};
    logic [2:0] modes [6] = '{3'h1, 3'h2, 3'h6, 3'h3, 3'h7, 3'h0};
    int fail_count = 0;
    int total_checks = 0;

    lat_lane_model u_lane (.pclk(pclk), .req(req), .err(err), .fuse(fz));

    lat_regs_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lane_fifo_err(err), .lane_active(act), .fuse_dual_a(fz),
        .fuse_dual_b(fz + 8'h01), .fuse_sgl_a_in1(fz + 8'h02),
        .fuse_sgl_b_in1(fz + 8'h03), .fuse_sgl_a_in2(fz + 8'h04),
        .fuse_sgl_b_in2(fz + 8'h05), .fuse_ofs_a({4'h0, fz}),
        .core_a_timing(ca), .core_b_timing(cb), .core_a_offset(ofs),
        .core_a_offset_valid(ov), .irq(irq));

    // 25 MHz bus clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Verdict and comparison
    task automatic end_sim;
        if (fail_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask

    // One APB transfer; bounded wait since pready stalls during load
    task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 50) begin
                fail_count++;
                end_sim;
            end
            @(posedge pclk);
        end
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdc(input string nm, input logic [9:0] i, input logic [31:0] e);
        apb(1'b0, i, 32'h0);
        chk(nm, rd, e);
    endtask

    // Fault pulse on lanes, then let the flag settle
    task automatic pulse(input logic [15:0] l);
        req <= l;
        @(posedge pclk);
        req <= 16'h0;
        repeat (3) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, req} = '0;
        act = 16'h00ff;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rdc("lane_flags", lat_pkg::IDX_LANE_FLAGS, 32'hffff);
        rdc("alarm_status", lat_pkg::IDX_ALARM_STATUS, 32'h20);
        for (int k = 0; k < 6; k++) begin
            rdc("trim_fuse", tidx[k], 32'(fz + 8'(k)));
            apb(1'b1, tidx[k], 32'h11 * (k + 1));
            rdc("trim_back", tidx[k], 32'h11 * (k + 1));
        end
        rdc("ofs_fuse", lat_pkg::IDX_OFS_A_DUAL_IN1, {24'h0, fz});
        apb(1'b1, lat_pkg::IDX_OFS_A_DUAL_IN1, 32'h777);
        // Six of the eight modes (not 4 or 5): which trims reach the cores
        for (int k = 0; k < 6; k++) begin
            m = modes[k];
            apb(1'b1, lat_pkg::IDX_MODE, {29'h0, m});
            repeat (2) @(posedge pclk);
            chk("core_a", ca, (!m[0] && m[1]) ? (m[2] ? 32'h55 : 32'h33) : 32'h11);
            chk("core_b", cb, (!m[0] && m[1]) ? (m[2] ? 32'h66 : 32'h44) : 32'h22);
            chk("offset", {ov, ofs}, (m == 3'h3) ? 32'h1777 : 32'h0);
        end
        // Load-done interrupt: masked, enabled, read-cleared
        chk("irq_off", irq, 1'b0);
        apb(1'b1, lat_pkg::IDX_IRQ_MASK, 32'h2);
        chk("irq_on", irq, 1'b1);
        rdc("irq_status", lat_pkg::IDX_IRQ_STATUS, 32'h2);
        chk("irq_clr", irq, 1'b0);
        apb(1'b1, lat_pkg::IDX_IRQ_MASK, 32'h1);
        apb(1'b1, lat_pkg::IDX_LANE_FLAGS, 32'h000f);
        rdc("w1c_lanes", lat_pkg::IDX_LANE_FLAGS, 32'hfff0);
        apb(1'b1, lat_pkg::IDX_ALARM_STATUS, 32'h20);
        rdc("clr_all", lat_pkg::IDX_LANE_FLAGS, 32'h0);
        rdc("clr_sum", lat_pkg::IDX_ALARM_STATUS, 32'h0);
        // Inactive lane flags its bit but not the summary
        pulse(16'h0200);
        rdc("lane9", lat_pkg::IDX_LANE_FLAGS, 32'h0200);
        rdc("sum_idle", lat_pkg::IDX_ALARM_STATUS, 32'h0);
        chk("irq_lane", irq, 1'b1);
        pulse(16'h0008);
        rdc("lane3", lat_pkg::IDX_LANE_FLAGS, 32'h0208);
        rdc("sum_act", lat_pkg::IDX_ALARM_STATUS, 32'h20);
        // A persisting fault beats the clear
        req <= 16'h0004;
        repeat (2) @(posedge pclk);
        apb(1'b1, lat_pkg::IDX_LANE_FLAGS, 32'h0004);
        rdc("persist", lat_pkg::IDX_LANE_FLAGS, 32'h020c);
        req <= 16'h0;
        rdc("unmapped", 10'h000, 32'h0);
        chk("slverr", perr, 1'b1);
        end_sim;
    end
endmodule
